/* design/mac_engine_map.vh */
// register offsets, field positions and reset values of the engine
`ifndef MAC_ENGINE_MAP_VH
`define MAC_ENGINE_MAP_VH

// byte offsets on the bus, one aligned word per register
`define OFS_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_A_HIGH 8'h08
`define OFS_A_LOW 8'h0C
`define OFS_B_HIGH 8'h10
`define OFS_B_LOW 8'h14
`define OFS_ACC_EXT 8'h18
`define OFS_ACC3 8'h1C
`define OFS_ACC2 8'h20
`define OFS_ACC1 8'h24
`define OFS_ACC0 8'h28
`define OFS_RND_HIGH 8'h2C
`define OFS_RND_LOW 8'h30
`define OFS_IRQ_STATUS 8'h34
`define OFS_IRQ_MASK 8'h38

// configuration register fields
`define CFG_MULT_ONLY 0
`define CFG_FRACT 1
`define CFG_SAT 2
`define CFG_CLR_ACC 3
`define CFG_SHIFT_DIR 4
`define CFG_SHIFT_GO 5
`define CFG_RESET 8'h00

// status register fields
`define STA_SOFT_OVF 0
`define STA_HARD_OVF 1
`define STA_ZERO 2
`define STA_NEG 3
`define STA_RESET 4'h0

// interrupt status and mask fields
`define IRQ_OP_DONE 0
`define IRQ_SHIFT_DONE 1
`define IRQ_OVF 2
`define IRQ_WIDTH 3

// system clock
`define CLK_PERIOD_NS 25
`define CLK_FREQ_MHZ 40

// data widths
`define OPND_W 16
`define ACC_W 40

// bus encodings
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0

`endif

/* design/round_unit.v */
// unbiased rounding and optional saturation of accumulator bits 31..16
`timescale 1ns/1ps
module round_unit #(
    parameter ACC_W = 40,
    parameter RND_W = 16
) (
    input wire [ACC_W-1:0] acc_i,
    input wire sat_en_i,
    output reg [RND_W-1:0] rnd_o
);
    wire [RND_W-1:0] upper;
    wire [RND_W-1:0] lower;
    wire round_up;
    wire in_range;
    wire ovf;
    wire [RND_W-1:0] sum;

    assign upper = acc_i[2*RND_W-1:RND_W];
    assign lower = acc_i[RND_W-1:0];
    // above half rounds up, exactly half goes to the even neighbour
    assign round_up = (lower > {1'b1, {(RND_W-1){1'b0}}}) ||
        ((lower == {1'b1, {(RND_W-1){1'b0}}}) && upper[0]);
    assign sum = upper + {{(RND_W-1){1'b0}}, round_up};
    // value fits in 16 fraction bits only if bits 39..31 agree
    assign in_range = (acc_i[ACC_W-1:2*RND_W-1] == {(ACC_W-2*RND_W+1){1'b0}})
        || (acc_i[ACC_W-1:2*RND_W-1] == {(ACC_W-2*RND_W+1){1'b1}});
    assign ovf = !in_range ||
        (round_up && (upper == {1'b0, {(RND_W-1){1'b1}}}));

    // saturation clamps towards the sign of the full accumulator
    always @*
    begin
        if (sat_en_i && ovf)
            rnd_o = acc_i[ACC_W-1] ? {1'b1, {(RND_W-1){1'b0}}}
                                   : {1'b0, {(RND_W-1){1'b1}}};
        else
            rnd_o = sum; // low 16 bits only, sign kept apart
    end
endmodule // round_unit

/* design/mult_acc_engine.v */
// signed 16x16 multiply-accumulate engine with an ahb-lite register slave
//
// Summary of operation
// - signed 16x16 multiply, 40-bit add
// - multiply or accumulate done in two cycles
// - rounded 16-bit result on third cycle
// - one-bit accumulator shift in one cycle
// - fifteen byte registers: config, status, data, interrupt status and mask
// - status holds overflow, zero, negative flags
// - each operand built from high, low bytes
// - accumulator: extension byte over four bytes
// - results to accumulator, rounding to own register
// - fractional bit clear: integer operands
// - integer mode: 40-bit integer, bit 39 sign
// - fractional bit set: point after bit 15
// - fractional accumulator point after bit 31
// - rounding keeps low 16 bits, sign separate
// - writing operand b low byte starts operation
// - config bit 0: accumulate or overwrite
// - unbiased rounding of accumulator bits 31..16
// - direction bit: 0 left, 1 right signed
`timescale 1ns/1ps
`include "mac_engine_map.vh"
module mult_acc_engine #(
    parameter OPND_W = `OPND_W,
    parameter ACC_W = `ACC_W
) (
    input wire CORE_CLK_I,
    input wire RST_N_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output reg [31:0] HRDATA_O,
    output reg HREADYOUT_O,
    output reg HRESP_O,
    output reg IRQ_O
);
    // bus data phase bookkeeping
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    wire addr_phase;
    wire [7:0] wdat;

    // software-visible state
    reg [7:0] config_r;
    reg [3:0] status_r;
    reg [7:0] a_high_r;
    reg [7:0] a_low_r;
    reg [7:0] b_high_r;
    reg [7:0] b_low_r;
    reg [ACC_W-1:0] acc_r;
    reg [OPND_W-1:0] rnd_r;
    reg [`IRQ_WIDTH-1:0] irq_sta_r;
    reg [`IRQ_WIDTH-1:0] irq_mask_r;

    // pipeline state
    reg stage1_r;
    reg stage2_r;
    reg round_go_r;
    reg clear_r;
    reg [ACC_W-1:0] product_r;
    reg shift_go_r;

    // write decode, taken at the end of the data phase
    wire wr_config;
    wire wr_status;
    wire wr_b_low;
    wire wr_acc_any;
    wire wr_acc0;
    wire wr_irq_sta;
    wire wr_irq_mask;

    // arithmetic
    wire signed [OPND_W-1:0] opnd_a;
    wire signed [OPND_W-1:0] opnd_b;
    wire signed [2*OPND_W-1:0] mult_raw;
    wire [ACC_W-1:0] mult_ext;
    wire [ACC_W-1:0] acc_base;
    wire [ACC_W-1:0] acc_sum;
    wire hard_ovf;
    wire soft_ovf;
    wire [ACC_W-1:0] acc_shifted;
    wire [OPND_W-1:0] rnd_val;
    wire [`IRQ_WIDTH-1:0] irq_set;

    reg [ACC_W-1:0] acc_nxt;
    reg [31:0] rdata_nxt;

    assign addr_phase = HSEL_I && HREADY_I && (HTRANS_I == `HTRANS_NONSEQ);
    // byte-wide registers take the low lane, the upper lanes are dropped
    assign wdat = HWDATA_I[7:0];

    assign wr_config = wr_pend_r && (wr_addr_r == `OFS_CONFIG);
    assign wr_status = wr_pend_r && (wr_addr_r == `OFS_STATUS);
    assign wr_b_low = wr_pend_r && (wr_addr_r == `OFS_B_LOW);
    assign wr_acc0 = wr_pend_r && (wr_addr_r == `OFS_ACC0);
    assign wr_acc_any = wr_pend_r && ((wr_addr_r == `OFS_ACC_EXT) ||
        (wr_addr_r == `OFS_ACC3) || (wr_addr_r == `OFS_ACC2) ||
        (wr_addr_r == `OFS_ACC1) || wr_acc0);
    assign wr_irq_sta = wr_pend_r && (wr_addr_r == `OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_pend_r && (wr_addr_r == `OFS_IRQ_MASK);

    // bus slave: zero wait states, every response okay
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA_O <= 32'h00000000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= `HRESP_OKAY;
        end
        else
        begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= `HRESP_OKAY;
            wr_pend_r <= addr_phase && HWRITE_I;
            if (addr_phase)
                wr_addr_r <= HADDR_I[7:0];
            // read data sampled at the address phase, held in the data phase
            if (addr_phase && !HWRITE_I)
                HRDATA_O <= rdata_nxt;
        end
    end

    // read multiplexer, unmapped offsets read as zero
    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (HADDR_I[7:0])
            `OFS_CONFIG: rdata_nxt[7:0] = config_r;
            `OFS_STATUS: rdata_nxt[3:0] = status_r;
            `OFS_A_HIGH: rdata_nxt[7:0] = a_high_r;
            `OFS_A_LOW: rdata_nxt[7:0] = a_low_r;
            `OFS_B_HIGH: rdata_nxt[7:0] = b_high_r;
            `OFS_B_LOW: rdata_nxt[7:0] = b_low_r;
            `OFS_ACC_EXT: rdata_nxt[7:0] = acc_r[39:32];
            `OFS_ACC3: rdata_nxt[7:0] = acc_r[31:24];
            `OFS_ACC2: rdata_nxt[7:0] = acc_r[23:16];
            `OFS_ACC1: rdata_nxt[7:0] = acc_r[15:8];
            `OFS_ACC0: rdata_nxt[7:0] = acc_r[7:0];
            `OFS_RND_HIGH: rdata_nxt[7:0] = rnd_r[15:8];
            `OFS_RND_LOW: rdata_nxt[7:0] = rnd_r[7:0];
            `OFS_IRQ_STATUS: rdata_nxt[`IRQ_WIDTH-1:0] = irq_sta_r;
            `OFS_IRQ_MASK: rdata_nxt[`IRQ_WIDTH-1:0] = irq_mask_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // operand bytes; nothing but software writes them
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            a_high_r <= 8'h00;
            a_low_r <= 8'h00;
            b_high_r <= 8'h00;
            b_low_r <= 8'h00;
        end
        else if (wr_pend_r)
        begin
            case (wr_addr_r)
                `OFS_A_HIGH: a_high_r <= wdat;
                `OFS_A_LOW: a_low_r <= wdat;
                `OFS_B_HIGH: b_high_r <= wdat;
                `OFS_B_LOW: b_low_r <= wdat;
                default: a_high_r <= a_high_r;
            endcase
        end
    end

    // configuration; clear and shift-go bits drop when their work is done
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            config_r <= `CFG_RESET;
        else if (wr_config)
            config_r <= {2'b00, wdat[5:0]};
        else
        begin
            if (stage2_r && clear_r)
                config_r[`CFG_CLR_ACC] <= 1'b0;
            if (shift_go_r)
                config_r[`CFG_SHIFT_GO] <= 1'b0;
        end
    end

    // start pulses: a b-low write starts the multiply, a config write
    // with shift-go set starts the shift
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            shift_go_r <= 1'b0;
            clear_r <= 1'b0;
            round_go_r <= 1'b0;
        end
        else
        begin
            stage1_r <= wr_b_low;
            stage2_r <= stage1_r;
            shift_go_r <= wr_config && wdat[`CFG_SHIFT_GO];
            // clear request is sampled when the operation is started
            if (wr_b_low)
                clear_r <= config_r[`CFG_CLR_ACC];
            else if (stage2_r)
                clear_r <= 1'b0;
            // third stage: round after an operation, a shift or an acc0 write
            round_go_r <= stage2_r || shift_go_r || wr_acc0;
        end
    end

    // operand assembly and product; stage one of two
    assign opnd_a = {a_high_r, a_low_r};
    assign opnd_b = {b_high_r, b_low_r};
    assign mult_raw = opnd_a * opnd_b;
    // fractional product 2.30 moves left once to sit at point 31
    assign mult_ext = config_r[`CFG_FRACT] ?
        {{(ACC_W-2*OPND_W-1){mult_raw[2*OPND_W-1]}}, mult_raw, 1'b0} :
        {{(ACC_W-2*OPND_W){mult_raw[2*OPND_W-1]}}, mult_raw};

    // product register holds the sign-extended 40-bit value
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            product_r <= {ACC_W{1'b0}};
        else if (stage1_r)
            product_r <= mult_ext;
    end

    // stage two adder; multiply-only adds to zero, a clear also starts at 0
    assign acc_base = (config_r[`CFG_MULT_ONLY] || clear_r) ?
        {ACC_W{1'b0}} : acc_r;
    assign acc_sum = acc_base + product_r;
    // signed overflow of the 40-bit adder
    assign hard_ovf = (acc_base[ACC_W-1] == product_r[ACC_W-1]) &&
        (acc_sum[ACC_W-1] != acc_base[ACC_W-1]);
    // result leaves the 32-bit range when bits 39..31 disagree
    assign soft_ovf = !((acc_sum[ACC_W-1:31] == 9'h000) ||
        (acc_sum[ACC_W-1:31] == 9'h1FF));

    // arithmetic shift by one; right shift copies bit 39
    assign acc_shifted = config_r[`CFG_SHIFT_DIR] ?
        {acc_r[ACC_W-1], acc_r[ACC_W-1:1]} :
        {acc_r[ACC_W-2:0], 1'b0};

    // accumulator next value: operation over shift over software write
    always @*
    begin
        acc_nxt = acc_r;
        if (stage2_r)
            acc_nxt = acc_sum;
        else if (shift_go_r)
            acc_nxt = acc_shifted;
        else if (wr_acc_any)
        begin
            case (wr_addr_r)
                `OFS_ACC_EXT: acc_nxt[39:32] = wdat;
                `OFS_ACC3: acc_nxt[31:24] = wdat;
                `OFS_ACC2: acc_nxt[23:16] = wdat;
                `OFS_ACC1: acc_nxt[15:8] = wdat;
                `OFS_ACC0: acc_nxt[7:0] = wdat;
                default: acc_nxt = acc_r;
            endcase
        end
    end

    // accumulator register
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            acc_r <= {ACC_W{1'b0}};
        else
            acc_r <= acc_nxt;
    end

    // status flags: set after stage two, shifts leave them alone;
    // overflow flags stay set until cleared by software or a clear request
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            status_r <= `STA_RESET;
        else if (stage2_r)
        begin
            status_r[`STA_ZERO] <= (acc_sum == {ACC_W{1'b0}});
            status_r[`STA_NEG] <= acc_sum[ACC_W-1];
            status_r[`STA_SOFT_OVF] <= soft_ovf ||
                (status_r[`STA_SOFT_OVF] && !clear_r);
            // multiply-only leaves the hard overflow flag alone unless a clear request zeroes it
            if (!config_r[`CFG_MULT_ONLY])
                status_r[`STA_HARD_OVF] <= hard_ovf ||
                    (status_r[`STA_HARD_OVF] && !clear_r);
            else if (clear_r)
                status_r[`STA_HARD_OVF] <= 1'b0;
        end
        else if (wr_status)
            status_r <= wdat[3:0];
    end

    // rounding engine on the accumulator as it now stands
    round_unit #(
        .ACC_W(ACC_W),
        .RND_W(OPND_W)
    ) u_round (
        .acc_i(acc_r),
        .sat_en_i(config_r[`CFG_SAT]),
        .rnd_o(rnd_val)
    );

    // rounding register updates one cycle after the accumulator
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rnd_r <= {OPND_W{1'b0}};
        else if (round_go_r)
            rnd_r <= rnd_val;
    end

    // interrupt events of this cycle
    assign irq_set[`IRQ_OP_DONE] = stage2_r;
    assign irq_set[`IRQ_SHIFT_DONE] = shift_go_r;
    assign irq_set[`IRQ_OVF] = stage2_r && (soft_ovf ||
        (hard_ovf && !config_r[`CFG_MULT_ONLY]));

    // sticky interrupt status, write one to clear; a new event wins
    always @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            irq_sta_r <= {`IRQ_WIDTH{1'b0}};
            irq_mask_r <= {`IRQ_WIDTH{1'b0}};
            IRQ_O <= 1'b0;
        end
        else
        begin
            irq_sta_r <= irq_set | (irq_sta_r &
                ~(wr_irq_sta ? wdat[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}}));
            if (wr_irq_mask)
                irq_mask_r <= wdat[`IRQ_WIDTH-1:0];
            // registered level, one cycle behind the status bits
            IRQ_O <= |(irq_sta_r & irq_mask_r);
        end
    end
endmodule // mult_acc_engine

/* test/mac_engine_checker_assertions.sv */
// bus-side checks on the multiply-accumulate engine ports
`timescale 1ns/1ps
module mac_engine_checker (
    input wire CORE_CLK_I,
    input wire RST_N_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire HREADY_I,
    input wire [31:0] HRDATA_O,
    input wire HREADYOUT_O,
    input wire HRESP_O,
    input wire IRQ_O
);
    logic [2:0] since_wr_r;
    wire take = HSEL_I && HREADY_I && HTRANS_I == 2'b10;
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // read address phases, any or at one offset
    sequence s_rd;
        take && !HWRITE_I;
    endsequence
    sequence s_rd_at(logic [7:0] ofs);
        take && !HWRITE_I && HADDR_I[7:0] == ofs;
    endsequence

    // cycles since a write; an irq must trace back to one
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
        if (!RST_N_I)
            since_wr_r <= 3'd7;
        else if (take && HWRITE_I)
            since_wr_r <= 3'd0;
        else if (since_wr_r != 3'd7)
            since_wr_r <= since_wr_r + 3'd1;

    a_ready_high: assert property (HREADYOUT_O)
        else $error("wait state inserted");
    a_resp_okay: assert property (!HRESP_O)
        else $error("error response");
    a_unmapped_zero: assert property (s_rd ##0 HADDR_I[7:0] > 8'h38
        |=> HRDATA_O == 32'h0) else $error("unmapped read not zero");
    a_byte_wide: assert property (s_rd |=> HRDATA_O[31:8] == 24'h0)
        else $error("read data above byte");
    a_cfg_bits: assert property (s_rd_at(8'h00)
        |=> HRDATA_O[7:6] == 2'b00) else $error("config spare bits set");
    a_status_bits: assert property (s_rd_at(8'h04)
        |=> HRDATA_O[7:4] == 4'h0) else $error("status spare bits set");
    a_rd_hold: assert property (!(take && !HWRITE_I)
        |=> $stable(HRDATA_O)) else $error("read data moved");
    a_irq_cause: assert property ($rose(IRQ_O) |-> since_wr_r <= 3'd6)
        else $error("irq without a recent write");
endmodule // mac_engine_checker

bind mult_acc_engine mac_engine_checker i_chk (.CORE_CLK_I(CORE_CLK_I),
    .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .IRQ_O(IRQ_O));

/* test/ahb_master_model.sv */
// bus master standing in for the processor core
`timescale 1ns/1ps
module ahb_master_model (
    input wire clk_i,
    input wire hready_i,
    input wire [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    // idle bus at time zero
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hwdata_o = 32'h0;
    end

    // bounded wait for the next edge with ready high
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready_i !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
        begin
            mult_acc_engine_tb.mismatches++;
            mult_acc_engine_tb.report_and_stop();
        end
    endtask

    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] ofs,
        input logic [7:0] wd, output logic [7:0] rd);
        hsel_o <= 1'b1;
        htrans_o <= 2'b10;
        haddr_o <= {24'h000000, ofs};
        hwrite_o <= wr;
        wait_rdy();
        htrans_o <= 2'b00;
        hwdata_o <= {24'h000000, wd};
        wait_rdy();
        rd = hrdata_i[7:0];
        // released data must not keep looking valid
        hwdata_o <= ~{24'h000000, wd};
    endtask
endmodule // ahb_master_model

/* test/mult_acc_engine_tb.sv */
// self-checking bench for the multiply-accumulate engine
`timescale 1ns/1ps
`include "mac_engine_map.vh"
module mult_acc_engine_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    int mismatches = 0;
    int n_compared = 0;
    logic [39:0] acc;
    logic [3:0] sta;
    logic [7:0] cfg, rd;
    logic [15:0] oa, ob;
    logic [39:0] rnd_tab [4] = '{40'h0012348000, 40'h0012358000,
        40'h0012348001, 40'h0012347FFF};

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    mult_acc_engine i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .IRQ_O(irq));
    ahb_master_model i_bus (.clk_i(clk), .hready_i(hreadyout),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
        .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));

    task automatic check(input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ofs, d);
        i_bus.xfer(1'b1, ofs, d, rd);
    endtask

    task automatic rdc(input logic [7:0] ofs, exp);
        i_bus.xfer(1'b0, ofs, 8'h00, rd);
        check(rd, exp);
    endtask

    // irq level, sampled once the edge's updates have landed
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge clk);
        #1 check({7'h00, irq}, {7'h00, e});
        @(posedge clk);
    endtask

    // start on the current operands, model the result alongside
    task automatic start;
        logic signed [39:0] p;
        logic [39:0] b;
        p = $signed(oa) * $signed(ob);
        if (cfg[1])
            p = p <<< 1;
        if (cfg[3])
        begin
            acc = 40'h0;
            sta = 4'h0;
            cfg[3] = 1'b0;
        end
        b = cfg[0] ? 40'h0 : acc;
        acc = b + p;
        // 40-bit adder overflow flag, untouched in multiply-only mode
        if (!cfg[0])
            sta[1] = sta[1] | (b[39] == p[39] && acc[39] != b[39]);
        sta[0] = sta[0] | (acc[39:31] != 9'h000 && acc[39:31] != 9'h1FF);
        sta[2] = (acc == 40'h0);
        sta[3] = acc[39];
        wr(`OFS_B_LOW, ob[7:0]);
    endtask

    task automatic op(input logic [15:0] a, b);
        oa = a;
        ob = b;
        wr(`OFS_A_HIGH, a[15:8]);
        wr(`OFS_A_LOW, a[7:0]);
        wr(`OFS_B_HIGH, b[15:8]);
        start();
    endtask

    // whole result after the pipeline has drained; saturation clamps
    // out-of-range values towards the accumulator sign
    task automatic chk_all;
        logic [15:0] r;
        logic up;
        up = (acc[15:0] > 16'h8000) || (acc[15:0] == 16'h8000 && acc[16]);
        r = acc[31:16] + {15'h0000, up};
        if (cfg[2] && ((acc[39:31] != 9'h000 && acc[39:31] != 9'h1FF) ||
            (up && acc[31:16] == 16'h7FFF)))
            r = acc[39] ? 16'h8000 : 16'h7FFF;
        repeat (3) @(posedge clk);
        rdc(`OFS_ACC_EXT, acc[39:32]);
        rdc(`OFS_ACC3, acc[31:24]);
        rdc(`OFS_ACC2, acc[23:16]);
        rdc(`OFS_ACC1, acc[15:8]);
        rdc(`OFS_ACC0, acc[7:0]);
        rdc(`OFS_RND_HIGH, r[15:8]);
        rdc(`OFS_RND_LOW, r[7:0]);
        rdc(`OFS_STATUS, {4'h0, sta});
    endtask

    task automatic setacc(input logic [39:0] v);
        acc = v;
        wr(`OFS_ACC_EXT, v[39:32]);
        wr(`OFS_ACC3, v[31:24]);
        wr(`OFS_ACC2, v[23:16]);
        wr(`OFS_ACC1, v[15:8]);
        wr(`OFS_ACC0, v[7:0]);
        chk_all();
    endtask

    task automatic shift(input logic dir);
        cfg[4] = dir;
        acc = dir ? {acc[39], acc[39:1]} : acc << 1;
        wr(`OFS_CONFIG, cfg | 8'h20);
        chk_all();
        rdc(`OFS_CONFIG, cfg);
    endtask

    // main sequence; reset reads and an unmapped write come first, then a back-to-back pair of operations
    initial
    begin
        acc = 40'h0;
        sta = 4'h0;
        cfg = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int o = 0; o < 64; o += 4)
            rdc(o[7:0], 8'h00);
        wr(8'h3C, 8'hA5);
        rdc(8'h3C, 8'h00);
        cfg = 8'h0A;
        wr(`OFS_CONFIG, cfg);
        op(16'h4000, 16'h2000);
        op(16'h4000, 16'hE000);
        chk_all();
        cfg = 8'h01;
        wr(`OFS_CONFIG, cfg);
        op(16'h1234, 16'hFEDC);
        chk_all();
        cfg = 8'h00;
        wr(`OFS_CONFIG, cfg);
        start();
        chk_all();
        rdc(`OFS_A_HIGH, 8'h12);
        cfg = 8'h0A;
        wr(`OFS_CONFIG, cfg);
        op(16'h8000, 16'h8000);
        chk_all();
        for (int i = 0; i < 4; i++)
            setacc(rnd_tab[i]);
        cfg = 8'h06;
        wr(`OFS_CONFIG, cfg);
        setacc(40'h007FFF8001);
        setacc(40'hFE00000000);
        cfg = 8'h02;
        wr(`OFS_CONFIG, cfg);
        wr(`OFS_IRQ_STATUS, 8'h07);
        setacc(40'h8012348001);
        shift(1'b1);
        shift(1'b0);
        rdc(`OFS_IRQ_STATUS, 8'h02);
        cfg = 8'h00;
        wr(`OFS_CONFIG, cfg);
        setacc(40'h7FFFFFFFFF);
        op(16'h0001, 16'h0001);
        chk_all();
        rdc(`OFS_IRQ_STATUS, 8'h07);
        sta = 4'h0;
        wr(`OFS_STATUS, 8'h00);
        rdc(`OFS_STATUS, 8'h00);
        wr(`OFS_IRQ_STATUS, 8'h07);
        cfg = 8'h09;
        wr(`OFS_CONFIG, cfg);
        op(16'h0002, 16'hFFFD);
        chk_all();
        chk_irq(1'b0);
        rdc(`OFS_IRQ_STATUS, 8'h01);
        wr(`OFS_IRQ_MASK, 8'h01);
        chk_irq(1'b1);
        wr(`OFS_IRQ_STATUS, 8'h01);
        chk_irq(1'b0);
        report_and_stop();
    end
endmodule // mult_acc_engine_tb
